/* include/dosd_params.svh */
// Constants for the drive output signal detect block.
// Assumes a 20 MHz clock and settings held by the host in its own units.
`ifndef DOSD_PARAMS_SVH
`define DOSD_PARAMS_SVH

`define DOSD_CLK_HZ 20000000
`define DOSD_TICK_MS 100
`define DOSD_TICK_CYCLES (`DOSD_CLK_HZ / 1000 * `DOSD_TICK_MS)

`define DOSD_KEEP_CODE 16'h270f
`define DOSD_PCT_FULL 24'h000064
`define DOSD_NEG_OFFSET 8'h64
`define DOSD_CODE_LIMIT 8'hc8
`define DOSD_FN_UP_TO_FREQ 8'h01
`define DOSD_FN_FREQ_THR 8'h04
`define DOSD_FN_OVERCURRENT 8'h0c
`define DOSD_FN_ZERO_CURRENT 8'h0d
`define DOSD_FN_CIRCUIT_FAULT 8'h5b
`define DOSD_ZERO_HOLD_TICKS 16'h0001
`define DOSD_TERMINALS 3

`define DOSD_UP_BAND_RST 7'h0a
`define DOSD_FWD_THR_RST 16'h003c
`define DOSD_OC_LEVEL_RST 8'h96
`define DOSD_OC_RETAIN_RST 16'h0001
`define DOSD_ZERO_LEVEL_RST 8'h05
`define DOSD_ZERO_TIME_RST 16'h0005

`endif

/* include/dosd_pkg.sv */
// Types for the drive output signal detect block.
// Assumes dosd_params.svh supplies the numeric constants.
package dosd_pkg;

  typedef struct packed {
    logic brakeTransistorAlarm;
    logic groundFaultAtStart;
    logic accelOvercurrentTrip;
    logic accelTripIsGround;
    logic outputPhaseLoss;
    logic paramStorageFault;
    logic processorFault;
    logic inrushLimiterFault;
  } dosd_faults_t;

  typedef struct packed {
    logic [6:0] upToFreqBand;
    logic [15:0] forwardFreqThreshold;
    logic [15:0] reverseFreqThreshold;
    logic [7:0] overcurrentLevel;
    logic [15:0] overcurrentDelay;
    logic [15:0] overcurrentRetention;
    logic overcurrentTripSelect;
    logic [7:0] zeroCurrentLevel;
    logic [15:0] zeroCurrentTime;
  } dosd_cfg_t;

  typedef struct packed {
    logic circuitFaultFlag;
    logic upToFreqFlag;
    logic freqThresholdFlag;
    logic overcurrentDetectFlag;
    logic zeroCurrentFlag;
  } dosd_flags_t;

  typedef enum logic [1:0] {
    DOSD_OC_IDLE,
    DOSD_OC_HOLD,
    DOSD_OC_LATCH
  } dosd_oc_state_t;

endpackage : dosd_pkg

/* src/dosd_timer.sv */
// Saturating tick counter that qualifies a level held for a programmed time.
// Assumes tick is a one-cycle pulse from the parent.
`timescale 1ns/100ps
module dosd_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic active,
  input wire logic [15:0] limit,
  output logic done
);
  logic [15:0] count;
  logic [15:0] next_count;

  always_comb begin
    next_count = count;
    if (!active) begin
      next_count = 16'h0000;
    end else if (tick && count != 16'hffff) begin
      next_count = count + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= 16'h0000;
    end else begin
      count <= next_count;
    end
  end

  assign done = active && (count >= limit);
endmodule : dosd_timer

/* src/dosd_detect.sv */
// Output signal detection: fault, frequency and current flags and
// terminal routing. Assumes all inputs synchronous to clk; frequencies in
// 0.1 Hz, currents and levels in percent of rated, times in 0.1 s ticks.
// What this block does
// - Circuit fault flag on listed trip causes
// - Codes 91/191 route circuit fault flag
// - Ground fault shown as accel trip counts
// - Up-to-frequency within percent band of setpoint
// - Codes 1/101 route up-to-frequency flag
// - Frequency flag at or above forward threshold
// - Reverse threshold unless 9999, then forward
// - Codes 4/104 route frequency flag
// - DC braking forces frequency flags off
// - Compare frequency before slip compensation
// - Overcurrent flag after level held delay
// - Overcurrent flag held retention time
// - Retention 9999 holds until next start
// - Trip select 1 shuts off output
// - After trip hold retention or until reset
// - Trip select change ignored while flag on
// - Codes 12/112 route overcurrent flag
// - Zero current flag after low time
// - Codes below 100 positive, 100-199 negative
// - Zero current flag held about 0.1 s
`timescale 1ns/100ps
`include "dosd_params.svh"
module dosd_detect
  import dosd_pkg::*;
#(
  parameter int TICK_CYCLES = `DOSD_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input dosd_cfg_t cfg,
  input dosd_faults_t faults,
  input wire logic faultReset,
  input wire logic running,
  input wire logic startCmd,
  input wire logic reverseRun,
  input wire logic dcBraking,
  input wire logic [15:0] preSlipFreq,
  input wire logic [15:0] setFreq,
  input wire logic [7:0] outCurrent,
  input wire logic [7:0] runTerminalSelector,
  input wire logic [7:0] relayTerminalSelector,
  input wire logic [7:0] openCollectorSelector,
  output dosd_flags_t flags,
  output logic currentDetectFault,
  output logic outputShutoff,
  output logic [`DOSD_TERMINALS-1:0] terminalOut
);

  // Routes one flag set to a terminal by its function code
  function automatic logic dosd_route(input logic [7:0] code, input dosd_flags_t f);
    logic [7:0] base;
    logic neg;
    logic act;
    base = code;
    neg = 1'b0;
    act = 1'b0;
    if (code >= `DOSD_CODE_LIMIT) begin
      return 1'b0;
    end else if (code >= `DOSD_NEG_OFFSET) begin
      base = code - `DOSD_NEG_OFFSET;
      neg = 1'b1;
    end
    if (base == `DOSD_FN_UP_TO_FREQ) begin
      act = f.upToFreqFlag;
    end else if (base == `DOSD_FN_FREQ_THR) begin
      act = f.freqThresholdFlag;
    end else if (base == `DOSD_FN_OVERCURRENT) begin
      act = f.overcurrentDetectFlag;
    end else if (base == `DOSD_FN_ZERO_CURRENT) begin
      act = f.zeroCurrentFlag;
    end else if (base == `DOSD_FN_CIRCUIT_FAULT) begin
      act = f.circuitFaultFlag;
    end
    return neg ? !act : act;
  endfunction : dosd_route

  // Tick generator
  logic [31:0] tickCount;
  logic [31:0] next_tickCount;
  logic tick;

  always_comb begin
    tick = (tickCount == 32'(TICK_CYCLES - 1));
    next_tickCount = tick ? 32'h0 : tickCount + 32'h1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tickCount <= 32'h0;
    end else begin
      tickCount <= next_tickCount;
    end
  end

  // Circuit fault and frequency comparisons
  logic circuitCause;
  logic [23:0] freqDiff;
  logic [23:0] freqBand;
  logic [15:0] activeThreshold;
  dosd_flags_t next_flags;
  logic ocFlag;
  logic zeroFlag;

  always_comb begin
    circuitCause = faults.brakeTransistorAlarm || faults.groundFaultAtStart
      || faults.outputPhaseLoss || faults.paramStorageFault
      || faults.processorFault || faults.inrushLimiterFault
      || (faults.accelOvercurrentTrip && faults.accelTripIsGround);
    freqDiff = (preSlipFreq >= setFreq) ? 24'(preSlipFreq - setFreq)
                                        : 24'(setFreq - preSlipFreq);
    freqBand = 24'(setFreq) * 24'(cfg.upToFreqBand);
    activeThreshold = cfg.forwardFreqThreshold;
    if (reverseRun && cfg.reverseFreqThreshold != `DOSD_KEEP_CODE) begin
      activeThreshold = cfg.reverseFreqThreshold;
    end
    next_flags = flags;
    // Set wins over a simultaneous reset
    next_flags.circuitFaultFlag = circuitCause
      || (flags.circuitFaultFlag && !faultReset);
    next_flags.upToFreqFlag = !dcBraking
      && (freqDiff * `DOSD_PCT_FULL <= freqBand);
    next_flags.freqThresholdFlag = !dcBraking
      && (preSlipFreq >= activeThreshold);
    next_flags.overcurrentDetectFlag = ocFlag;
    next_flags.zeroCurrentFlag = zeroFlag;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

  // Overcurrent detection
  logic ocOver;
  logic ocQualified;
  logic startEdge;
  logic startSeen;
  logic ocTripNow;
  dosd_oc_state_t ocState;
  dosd_oc_state_t next_ocState;
  logic [15:0] retainCount;
  logic [15:0] next_retainCount;
  logic next_currentDetectFault;
  logic next_startSeen;

  assign ocOver = running && (outCurrent >= cfg.overcurrentLevel);

  dosd_timer ocTimer (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .active(ocOver),
    .limit(cfg.overcurrentDelay),
    .done(ocQualified)
  );

  always_comb begin
    startEdge = startCmd && !startSeen;
    next_startSeen = startCmd;
    next_ocState = ocState;
    next_retainCount = retainCount;
    ocTripNow = 1'b0;
    case (ocState)
      DOSD_OC_IDLE: begin
        next_retainCount = 16'h0000;
        if (ocQualified) begin
          ocTripNow = cfg.overcurrentTripSelect;
          if (cfg.overcurrentRetention == `DOSD_KEEP_CODE) begin
            next_ocState = DOSD_OC_LATCH;
          end else begin
            next_ocState = DOSD_OC_HOLD;
          end
        end
      end
      DOSD_OC_HOLD: begin
        if (retainCount >= cfg.overcurrentRetention) begin
          next_ocState = DOSD_OC_IDLE;
        end else if (tick) begin
          next_retainCount = retainCount + 16'h0001;
        end
      end
      DOSD_OC_LATCH: begin
        if (currentDetectFault ? faultReset : startEdge) begin
          next_ocState = DOSD_OC_IDLE;
        end
      end
      default: begin
        next_ocState = DOSD_OC_IDLE;
      end
    endcase
    ocFlag = (next_ocState != DOSD_OC_IDLE);
    next_currentDetectFault = ocTripNow
      || (currentDetectFault && !faultReset);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ocState <= DOSD_OC_IDLE;
      retainCount <= 16'h0000;
      currentDetectFault <= 1'b0;
      startSeen <= 1'b0;
    end else begin
      ocState <= next_ocState;
      retainCount <= next_retainCount;
      currentDetectFault <= next_currentDetectFault;
      startSeen <= next_startSeen;
    end
  end

  assign outputShutoff = currentDetectFault;

  // Zero current detection
  logic zeroLow;
  logic zeroQualified;
  logic [15:0] zeroHold;
  logic [15:0] next_zeroHold;

  assign zeroLow = running && (cfg.zeroCurrentLevel != 8'h00)
    && (outCurrent < cfg.zeroCurrentLevel);

  dosd_timer zeroTimer (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .active(zeroLow),
    .limit(cfg.zeroCurrentTime),
    .done(zeroQualified)
  );

  always_comb begin
    next_zeroHold = zeroHold;
    if (zeroQualified) begin
      next_zeroHold = `DOSD_ZERO_HOLD_TICKS;
    end else if (tick && zeroHold != 16'h0000) begin
      next_zeroHold = zeroHold - 16'h0001;
    end
    zeroFlag = zeroQualified || (next_zeroHold != 16'h0000);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      zeroHold <= 16'h0000;
    end else begin
      zeroHold <= next_zeroHold;
    end
  end

  // Terminal routing
  logic [7:0] selectors [`DOSD_TERMINALS];
  logic [`DOSD_TERMINALS-1:0] next_terminalOut;

  assign selectors[0] = runTerminalSelector;
  assign selectors[1] = relayTerminalSelector;
  assign selectors[2] = openCollectorSelector;

  for (genvar t = 0; t < `DOSD_TERMINALS; t++) begin : g_term
    assign next_terminalOut[t] = dosd_route(selectors[t], flags);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      terminalOut <= '0;
    end else begin
      terminalOut <= next_terminalOut;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  circuit_fault_set_a: assert property (
    circuitCause |=> flags.circuitFaultFlag
  ) else $error("circuit fault flag not set by cause");

  ground_alias_a: assert property (
    faults.accelOvercurrentTrip && faults.accelTripIsGround |=> flags.circuitFaultFlag
  ) else $error("ground fault alias did not set circuit fault");

  up_to_freq_a: assert property (
    !dcBraking && (freqDiff * `DOSD_PCT_FULL <= freqBand) |=> flags.upToFreqFlag
  ) else $error("up-to-frequency flag missing inside band");

  freq_thr_sel_a: assert property (
    !dcBraking && reverseRun && cfg.reverseFreqThreshold != `DOSD_KEEP_CODE
      && preSlipFreq < cfg.reverseFreqThreshold |=> !flags.freqThresholdFlag
  ) else $error("reverse threshold not used");

  dc_brake_off_a: assert property (
    dcBraking |=> !flags.upToFreqFlag && !flags.freqThresholdFlag
  ) else $error("frequency flag active during dc braking");

  oc_qualify_a: assert property (
    ocState == DOSD_OC_IDLE && !ocOver |=> ocState == DOSD_OC_IDLE
      && !flags.overcurrentDetectFlag
  ) else $error("overcurrent flag without qualified level");

  oc_latch_hold_a: assert property (
    ocState == DOSD_OC_LATCH && !startEdge && !faultReset
      |=> ocState == DOSD_OC_LATCH && flags.overcurrentDetectFlag
  ) else $error("latched overcurrent flag dropped early");

  oc_trip_a: assert property (
    ocState == DOSD_OC_IDLE && ocQualified && cfg.overcurrentTripSelect
      |=> currentDetectFault && outputShutoff
  ) else $error("trip select did not raise fault");

  late_trip_a: assert property (
    $rose(currentDetectFault) |-> $past(ocState) == DOSD_OC_IDLE
  ) else $error("trip raised while flag already on");

  zero_hold_a: assert property (
    zeroQualified ##1 !zeroQualified && !tick |-> zeroFlag
  ) else $error("zero current flag not held");

  term_pol_a: assert property (
    openCollectorSelector == 8'h65 && $stable(openCollectorSelector)
      |=> terminalOut[2] == !$past(flags.upToFreqFlag)
  ) else $error("negative polarity routing wrong");

endmodule : dosd_detect

/* verif/dosd_term_watch.sv */
// Model of the controller that watches the three output terminals.
// Assumes terminalOut is registered on the rising edge of clk.
`timescale 1ns/100ps
module dosd_term_watch (
  input wire logic clk,
  input wire logic [2:0] terminalOut,
  output logic [2:0] seen
);
  // A slow controller: it latches the terminals one edge late
  always_ff @(posedge clk) begin
    seen <= terminalOut;
  end
endmodule : dosd_term_watch

/* verif/drive_output_signal_detect_bench.sv */
// Self-checking bench for the output signal detect block.
// Assumes a 10-cycle tick, so every timed setting is short.
`timescale 1ns/100ps
`include "dosd_params.svh"
module drive_output_signal_detect_bench
  import dosd_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  dosd_cfg_t cfg;
  dosd_faults_t faults;
  logic faultReset, running, startCmd, reverseRun, dcBraking, up, fd;
  logic [15:0] preSlipFreq, setFreq, lfsr, thr;
  logic [7:0] outCurrent, selRun, selRelay, selOc;
  dosd_flags_t flags;
  logic currentDetectFault, outputShutoff;
  logic [2:0] terminalOut, seen;
  logic [9:0] expQ[$];
  logic [7:0] causes[7] = '{8'h80, 8'h40, 8'h30, 8'h08, 8'h04, 8'h02, 8'h01};
  int error_cnt = 0;
  int total_checks = 0;
  int cycles = 0;
  event chk;

  always #25 clk = ~clk;

  dosd_detect #(.TICK_CYCLES(10)) u_dut (.clk(clk), .rst(rst), .cfg(cfg), .faults(faults),
    .faultReset(faultReset), .running(running), .startCmd(startCmd),
    .reverseRun(reverseRun), .dcBraking(dcBraking), .preSlipFreq(preSlipFreq),
    .setFreq(setFreq), .outCurrent(outCurrent), .runTerminalSelector(selRun),
    .relayTerminalSelector(selRelay), .openCollectorSelector(selOc), .flags(flags),
    .currentDetectFault(currentDetectFault), .outputShutoff(outputShutoff),
    .terminalOut(terminalOut));

  dosd_term_watch u_watch (.clk(clk), .terminalOut(terminalOut), .seen(seen));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic cmp_obs(input logic [9:0] got, input logic [9:0] want);
    total_checks++;
    if (got !== want) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : cmp_obs

  task automatic note(input int n, input logic [4:0] f, input logic [2:0] t, input logic flt);
    repeat (n) @(negedge clk);
    expQ.push_back({f, t, flt, flt});
    -> chk;
  endtask : note

  task automatic wrap_up;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  // Oldest note is compared against the settled outputs
  always @(chk) begin
    cmp_obs({flags, seen, currentDetectFault, outputShutoff}, expQ.pop_front());
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  initial begin
    cfg = '{`DOSD_UP_BAND_RST, `DOSD_FWD_THR_RST, `DOSD_KEEP_CODE, `DOSD_OC_LEVEL_RST,
      16'h0000, `DOSD_OC_RETAIN_RST, 1'b0, `DOSD_ZERO_LEVEL_RST, `DOSD_ZERO_TIME_RST};
    faults = '0;
    {faultReset, startCmd, reverseRun, dcBraking} = 4'h0;
    running = 1'b1;
    preSlipFreq = 16'h01f4;
    setFreq = 16'h01f4;
    outCurrent = 8'h32;
    selRun = 8'h5b;
    selRelay = 8'hbf;
    selOc = 8'h01;
    lfsr = 16'h0025;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    note(6, 5'b01100, 3'b110, 1'b0);
    for (int i = 0; i < 7; i++) begin
      faults = causes[i];
      note(4, 5'b11100, 3'b101, 1'b0);
      faults = '0;
      faultReset = 1'b1;
      @(negedge clk);
      faultReset = 1'b0;
      note(4, 5'b01100, 3'b110, 1'b0);
    end
    selRun = 8'h04;
    selRelay = 8'h68;
    selOc = 8'h65;
    setFreq = 16'h03e8;
    cfg.reverseFreqThreshold = 16'h00c8;
    for (int i = 0; i < 10; i++) begin
      lfsr = lfsr_next(lfsr);
      preSlipFreq = lfsr[11] ? {8'h00, lfsr[7:0]} : 16'h0384 + {8'h00, lfsr[7:0]};
      reverseRun = lfsr[12] ^ i[0];
      if (i >= 6) begin
        cfg.reverseFreqThreshold = `DOSD_KEEP_CODE;
        reverseRun = 1'b1;
        preSlipFreq = 16'h0039 + i[15:0];
      end
      thr = (reverseRun && cfg.reverseFreqThreshold != 16'h270f) ? 16'h00c8 : 16'h003c;
      up = preSlipFreq >= 16'h0384 && preSlipFreq <= 16'h044c;
      fd = preSlipFreq >= thr;
      note(4, {1'b0, up, fd, 2'b00}, {~up, ~fd, fd}, 1'b0);
    end
    preSlipFreq = 16'h03e8;
    dcBraking = 1'b1;
    note(4, 5'b00000, 3'b110, 1'b0);
    dcBraking = 1'b0;
    {reverseRun, selRun, selRelay, selOc} = {1'b0, 8'h0c, 8'h70, 8'h0d};
    preSlipFreq = 16'h01f4;
    setFreq = 16'h01f4;
    cfg.overcurrentDelay = 16'h0003;
    cfg.overcurrentRetention = `DOSD_KEEP_CODE;
    cfg.overcurrentTripSelect = 1'b1;
    outCurrent = 8'h96;
    note(2, 5'b01100, 3'b010, 1'b0);
    note(60, 5'b01110, 3'b001, 1'b1);
    outCurrent = 8'h32;
    note(40, 5'b01110, 3'b001, 1'b1);
    faultReset = 1'b1;
    @(negedge clk);
    faultReset = 1'b0;
    note(6, 5'b01100, 3'b010, 1'b0);
    cfg.overcurrentTripSelect = 1'b0;
    outCurrent = 8'h96;
    note(60, 5'b01110, 3'b001, 1'b0);
    cfg.overcurrentTripSelect = 1'b1;
    note(20, 5'b01110, 3'b001, 1'b0);
    outCurrent = 8'h32;
    startCmd = 1'b1;
    note(6, 5'b01100, 3'b010, 1'b0);
    {startCmd, cfg.overcurrentTripSelect} = 2'b00;
    cfg.overcurrentDelay = 16'h0000;
    cfg.overcurrentRetention = 16'h0003;
    outCurrent = 8'h96;
    repeat (2) @(negedge clk);
    outCurrent = 8'h32;
    note(8, 5'b01110, 3'b001, 1'b0);
    note(40, 5'b01100, 3'b010, 1'b0);
    outCurrent = 8'h02;
    note(20, 5'b01100, 3'b010, 1'b0);
    note(60, 5'b01101, 3'b110, 1'b0);
    outCurrent = 8'h32;
    note(30, 5'b01100, 3'b010, 1'b0);
    repeat (2) @(negedge clk);
    wrap_up();
  end
endmodule : drive_output_signal_detect_bench
